//--- adc_channel_sync_host_port.sv
`timescale 1ns/1ps
`include "adc_sync_port_map.svh"

module adc_channel_sync_host_port #(
  parameter bit ten_bit_variant = 1'b0,
  parameter bit two_input_variant = 1'b0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic conversion_clock,
  input wire logic read_strobe_b,
  input wire logic write_strobe_b,
  input wire logic chip_select_low_active,
  input wire logic chip_select_high_active,
  input wire logic [`BUS_WIDTH-1:0] data_in,
  input wire logic [`BUS_WIDTH-1:0] sample_ch1,
  input wire logic [`BUS_WIDTH-1:0] sample_ch2,
  input wire logic [`BUS_WIDTH-1:0] sample_ch3,
  input wire logic [`BUS_WIDTH-1:0] sample_ch4,
  output logic [`BUS_WIDTH-1:0] data_out,
  output logic data_oe,
  output logic channel_one_marker_b,
  output logic [`REG_WIDTH-1:0] control_word_a,
  output logic [`REG_WIDTH-1:0] control_word_b
);

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic rst_stage_reg;
  logic rst_n_sync;

  // two flops so every register leaves reset on the same edge
  // the raw pin asserts at once; only the release is retimed
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_stage_reg <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_stage_reg <= 1'b1;
      rst_n_sync <= rst_stage_reg;
    end
  end

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic conv_level;
  logic read_b_level;
  logic write_b_level;
  logic cs_low_level;
  logic cs_high_level;
  logic [`BUS_WIDTH-1:0] data_level;

  pin_sync #(.width(1), .init(1'b0)) sync_conv (
    .clock(clock),
    .rst_n_sync(rst_n_sync),
    .pin(conversion_clock),
    .level(conv_level)
  );

  pin_sync #(.width(1), .init(1'b1)) sync_read (
    .clock(clock),
    .rst_n_sync(rst_n_sync),
    .pin(read_strobe_b),
    .level(read_b_level)
  );

  pin_sync #(.width(1), .init(1'b1)) sync_write (
    .clock(clock),
    .rst_n_sync(rst_n_sync),
    .pin(write_strobe_b),
    .level(write_b_level)
  );

  pin_sync #(.width(1), .init(1'b1)) sync_cs_low (
    .clock(clock),
    .rst_n_sync(rst_n_sync),
    .pin(chip_select_low_active),
    .level(cs_low_level)
  );

  pin_sync #(.width(1), .init(1'b0)) sync_cs_high (
    .clock(clock),
    .rst_n_sync(rst_n_sync),
    .pin(chip_select_high_active),
    .level(cs_high_level)
  );

  // data travels with the strobes, so both arrive with equal latency
  pin_sync #(.width(`BUS_WIDTH), .init('0)) sync_data (
    .clock(clock),
    .rst_n_sync(rst_n_sync),
    .pin(data_in),
    .level(data_level)
  );

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  // the pointer counts reads, not conversion edges
  adc_sync_port_pkg::bus_phase_type phase_reg;
  adc_sync_port_pkg::bus_phase_type phase_next;
  adc_sync_port_pkg::channel_index_type read_ptr_reg;
  adc_sync_port_pkg::channel_index_type read_ptr_next;
  logic conv_prev_reg;
  logic resync_pending_reg;
  logic readback_sel_reg;
  logic [`BUS_WIDTH-1:0] write_word_reg;

  // ----------------------------------------------------------------------
  // strobe decode
  // ----------------------------------------------------------------------
  wire chip_selected = !cs_low_level && cs_high_level;
  wire read_active = chip_selected && !read_b_level;
  wire write_active = chip_selected && !write_b_level;
  wire read_start = (phase_reg == adc_sync_port_pkg::phase_idle) && read_active;
  wire write_start = (phase_reg == adc_sync_port_pkg::phase_idle) && write_active && !read_active;
  wire read_end = (phase_reg == adc_sync_port_pkg::phase_read) && !read_active;
  wire write_end = (phase_reg == adc_sync_port_pkg::phase_write) && !write_active;

  // the conversion clock only paces; no start pulse is derived from it
  wire conv_fall = conv_prev_reg && !conv_level;

  // ----------------------------------------------------------------------
  // channel configuration
  // ----------------------------------------------------------------------
  wire [1:0] chan_sel = control_word_a[`CWA_CHSEL_LSB +: 2];
  wire diff_mode = |control_word_a[`CWA_DIFF_LSB +: 2];

  // differential pairs halve the channel count, as does a two-input part
  wire [1:0] last_se = two_input_variant ? {1'b0, chan_sel[0]} : chan_sel;
  wire [1:0] last_diff = two_input_variant ? 2'h0 : {1'b0, chan_sel[0]};
  wire [1:0] last_index = diff_mode ? last_diff : last_se;
  wire multi_channel = last_index != 2'h0;
  wire readback_on = control_word_b[`CWB_READBACK_BIT];

  // ----------------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------------
  wire [1:0] write_sel = write_word_reg[`REG_SEL_LSB +: 2];
  wire [`REG_WIDTH-1:0] write_value = write_word_reg[`REG_WIDTH-1:0];
  wire write_a = write_end && (write_sel == `REG_SEL_A);
  wire write_b = write_end && (write_sel == `REG_SEL_B);
  wire device_reset = write_b && write_value[`CWB_DEVICE_RESET_BIT];
  wire marker_reset_req = write_b && write_value[`CWB_MARKER_RESET_BIT];

  // ----------------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------------
  wire [`REG_WIDTH-1:0] readback_reg = readback_sel_reg ? control_word_b : control_word_a;
  wire [`BUS_WIDTH-1:0] readback_wide = {2'h0, readback_reg};
  wire [`BUS_WIDTH-1:0] readback_shift = ten_bit_variant ?
                                         (readback_wide >> `TEN_BIT_SHIFT) :
                                         readback_wide;
  wire [`BUS_WIDTH-1:0] readback_word = readback_shift |
                                        (`BUS_WIDTH'(1) << `READBACK_MARKER_BIT);
  wire [`BUS_WIDTH-1:0] sample_word = (read_ptr_reg == 2'h0) ? sample_ch1 :
                                      (read_ptr_reg == 2'h1) ? sample_ch2 :
                                      (read_ptr_reg == 2'h2) ? sample_ch3 :
                                      sample_ch4;
  wire [`BUS_WIDTH-1:0] read_word = readback_on ? readback_word : sample_word;

  // ----------------------------------------------------------------------
  // bus phase
  // ----------------------------------------------------------------------
  // one access at a time; a read beats a write seen in the same cycle
  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      adc_sync_port_pkg::phase_idle: begin
        if (read_start) begin
          phase_next = adc_sync_port_pkg::phase_read;
        end else if (write_start) begin
          phase_next = adc_sync_port_pkg::phase_write;
        end
      end
      adc_sync_port_pkg::phase_read: begin
        if (read_end) begin
          phase_next = adc_sync_port_pkg::phase_idle;
        end
      end
      adc_sync_port_pkg::phase_write: begin
        if (write_end) begin
          phase_next = adc_sync_port_pkg::phase_idle;
        end
      end
      default: begin
        phase_next = adc_sync_port_pkg::phase_idle;
      end
    endcase
  end

  // conversion clock history rides with the phase register
  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      phase_reg <= adc_sync_port_pkg::phase_idle;
      conv_prev_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      conv_prev_reg <= conv_level;
    end
  end

  // ----------------------------------------------------------------------
  // write capture and control words
  // ----------------------------------------------------------------------
  // the word is sampled while the strobe is low and acted on at release
  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      write_word_reg <= '0;
    end else if (phase_reg == adc_sync_port_pkg::phase_write && write_active) begin
      write_word_reg <= data_level;
    end else if (write_start) begin
      write_word_reg <= data_level;
    end
  end

  // the device reset bit reloads defaults and is not kept itself
  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      control_word_a <= `CONTROL_WORD_A_RESET;
      control_word_b <= `CONTROL_WORD_B_RESET;
    end else if (device_reset) begin
      control_word_a <= `CONTROL_WORD_A_RESET;
      control_word_b <= `CONTROL_WORD_B_RESET;
    end else if (write_a) begin
      control_word_a <= write_value;
    end else if (write_b) begin
      control_word_b <= write_value;
    end
  end

  // ----------------------------------------------------------------------
  // marker realignment request
  // ----------------------------------------------------------------------
  // a request landing on the consuming edge survives: set beats clear
  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      resync_pending_reg <= 1'b0;
    end else if (marker_reset_req) begin
      resync_pending_reg <= 1'b1;
    end else if (conv_fall) begin
      resync_pending_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // channel pointer
  // ----------------------------------------------------------------------
  // the pointer follows reads, so a missed or doubled read slips it
  always_comb begin
    read_ptr_next = read_ptr_reg;
    if (conv_fall && resync_pending_reg) begin
      read_ptr_next = 2'h0;
    end else if (read_end && !readback_on) begin
      if (read_ptr_reg >= last_index) begin
        read_ptr_next = 2'h0;
      end else begin
        read_ptr_next = read_ptr_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      read_ptr_reg <= 2'h0;
    end else begin
      read_ptr_reg <= read_ptr_next;
    end
  end

  // ----------------------------------------------------------------------
  // readback sequencing
  // ----------------------------------------------------------------------
  // any control_word_b write restarts the pair at control_word_a
  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      readback_sel_reg <= 1'b0;
    end else if (write_b) begin
      readback_sel_reg <= 1'b0;
    end else if (read_end && readback_on) begin
      readback_sel_reg <= !readback_sel_reg;
    end
  end

  // ----------------------------------------------------------------------
  // channel one marker
  // ----------------------------------------------------------------------
  // in multi-channel sample mode updated only on falling edges so the low lasts a whole period
  wire marker_low_now = multi_channel && (read_ptr_next == 2'h0);

  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      channel_one_marker_b <= 1'b1;
    end else if (readback_on) begin
      channel_one_marker_b <= 1'b0;
    end else if (!multi_channel) begin
      channel_one_marker_b <= 1'b1;
    end else if (conv_fall) begin
      channel_one_marker_b <= !marker_low_now;
    end
  end

  // ----------------------------------------------------------------------
  // data bus drive
  // ----------------------------------------------------------------------
  // word is frozen at strobe start so it cannot change under the host
  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      data_out <= '0;
      data_oe <= 1'b0;
    end else if (read_start) begin
      data_out <= read_word;
      data_oe <= 1'b1;
    end else if (read_end) begin
      data_oe <= 1'b0;
    end
  end

endmodule : adc_channel_sync_host_port

//--- adc_sync_port_map.svh
`ifndef ADC_SYNC_PORT_MAP_SVH
`define ADC_SYNC_PORT_MAP_SVH

// ----------------------------------------------------------------------
// host word layout
// ----------------------------------------------------------------------
`define BUS_WIDTH 12
`define REG_WIDTH 10
`define REG_SEL_LSB 10
`define REG_SEL_A 2'h0
`define REG_SEL_B 2'h1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CONTROL_WORD_A_RESET 10'h020
`define CONTROL_WORD_B_RESET 10'h030

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CWA_POWER_DOWN_BIT 2
`define CWA_CHSEL_LSB 3
`define CWA_DIFF_LSB 5
`define CWB_DEVICE_RESET_BIT 0
`define CWB_MARKER_RESET_BIT 1
`define CWB_READBACK_BIT 9
`define READBACK_MARKER_BIT 4
`define TEN_BIT_SHIFT 2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLOCK_HZ 10000000
`define CONV_CLOCK_MIN_HZ 100000
`define CONV_PERIOD_MAX_CYCLES (`CLOCK_HZ / `CONV_CLOCK_MIN_HZ)

`endif

//--- adc_sync_port_pkg.sv
package adc_sync_port_pkg;

  // ----------------------------------------------------------------------
  // host bus phase
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    phase_idle = 2'b00,
    phase_read = 2'b01,
    phase_write = 2'b10
  } bus_phase_type;

  typedef logic [1:0] channel_index_type;

endpackage : adc_sync_port_pkg

//--- pin_sync.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// three-stage pin synchroniser
// ----------------------------------------------------------------------
module pin_sync #(
  parameter int width = 1,
  parameter logic [width-1:0] init = '0
) (
  input wire logic clock,
  input wire logic rst_n_sync,
  input wire logic [width-1:0] pin,
  output logic [width-1:0] level
);

  logic [width-1:0] stage1_reg;
  logic [width-1:0] stage2_reg;
  logic [width-1:0] stage3_reg;
  logic [width-1:0] level_next;

  // per bit: take the agreed value, hold where the two stages still differ
  assign level_next = (stage2_reg & stage3_reg) | (level & (stage2_reg ^ stage3_reg));

  // stage1 is read by stage2 alone to keep metastability contained
  always_ff @(posedge clock or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      stage1_reg <= init;
      stage2_reg <= init;
      stage3_reg <= init;
      level <= init;
    end else begin
      stage1_reg <= pin;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      level <= level_next;
    end
  end

endmodule : pin_sync

//--- adc_channel_sync_host_port_sva.sv
`timescale 1ns/1ps
`include "adc_sync_port_map.svh"

// ----------------------------------------------------------------------
// port checker
// ----------------------------------------------------------------------
module adc_channel_sync_host_port_sva (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic conversion_clock,
  input wire logic read_strobe_b,
  input wire logic write_strobe_b,
  input wire logic chip_select_low_active,
  input wire logic chip_select_high_active,
  input wire logic [`BUS_WIDTH-1:0] data_out,
  input wire logic data_oe,
  input wire logic channel_one_marker_b,
  input wire logic [`REG_WIDTH-1:0] control_word_a,
  input wire logic [`REG_WIDTH-1:0] control_word_b
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // pins cross three sync flops, so each cause sits several edges back
  a_read_select: assert property (
    $rose(data_oe) |-> !$past(read_strobe_b, 3) && !$past(chip_select_low_active, 3)
      && $past(chip_select_high_active, 3)) else $error("bus driven without a selected read");
  a_read_release: assert property (
    $rose(read_strobe_b) |-> ##[1:7] !data_oe) else $error("bus still driven after read");
  a_data_hold: assert property (
    data_oe && $past(data_oe) |-> $stable(data_out)) else $error("read word moved mid read");
  a_single_idle: assert property (
    (control_word_a[4:3] == 2'h0 && !control_word_b[9])[*3] |-> channel_one_marker_b)
    else $error("marker active with one channel");
  a_readback_low: assert property (
    control_word_b[9][*3] |-> !channel_one_marker_b) else $error("marker not low in readback");
  // config changes may move the marker at once; all other moves follow a falling edge
  a_marker_at_fall: assert property (
    $changed(channel_one_marker_b) && $past(control_word_a, 3) == control_word_a
      && $past(control_word_b, 3) == control_word_b
      |-> $past(conversion_clock, 8) && !$past(conversion_clock, 2))
    else $error("marker moved away from a falling edge");
  a_marker_width: assert property (
    $fell(channel_one_marker_b) && !control_word_b[9] |=> !channel_one_marker_b [*8])
    else $error("marker pulse too short");
  a_write_select: assert property (
    $changed(control_word_a) |-> $past(write_strobe_b, 2) && !$past(write_strobe_b, 9)
      && !$past(chip_select_low_active, 5) && $past(chip_select_high_active, 5))
    else $error("control_word_a changed without a write");
  a_cwb_write: assert property (
    $changed(control_word_b) |-> $past(write_strobe_b, 2) && !$past(write_strobe_b, 9))
    else $error("control_word_b changed without a write");
endmodule : adc_channel_sync_host_port_sva

bind adc_channel_sync_host_port adc_channel_sync_host_port_sva chk (.clock(clock),
  .rst_b(rst_b), .conversion_clock(conversion_clock), .read_strobe_b(read_strobe_b),
  .write_strobe_b(write_strobe_b), .chip_select_low_active(chip_select_low_active),
  .chip_select_high_active(chip_select_high_active), .data_out(data_out),
  .data_oe(data_oe), .channel_one_marker_b(channel_one_marker_b),
  .control_word_a(control_word_a), .control_word_b(control_word_b));

//--- host_bus_model.sv
`timescale 1ns/1ps
`include "adc_sync_port_map.svh"

// ----------------------------------------------------------------------
// host processor on the parallel bus
// ----------------------------------------------------------------------
module host_bus_model #(
  parameter int half_period = 20
) (
  input wire logic clock,
  input wire logic [`BUS_WIDTH-1:0] data_out,
  input wire logic data_oe,
  input wire logic channel_one_marker_b,
  output logic conversion_clock,
  output logic read_strobe_b,
  output logic write_strobe_b,
  output logic chip_select_low_active,
  output logic chip_select_high_active,
  output logic [`BUS_WIDTH-1:0] data_in
);
  int phase_count = 0;

  // idle bus at time zero
  initial begin
    conversion_clock = 1'b1;
    read_strobe_b = 1'b1;
    write_strobe_b = 1'b1;
    chip_select_low_active = 1'b0;
    chip_select_high_active = 1'b1;
    data_in = 12'h000;
  end

  // free-running 50 percent clock, 250 kHz at a 10 MHz system clock
  always @(posedge clock) begin
    if (phase_count == half_period - 1) begin
      phase_count <= 0;
      conversion_clock <= ~conversion_clock;
    end else begin
      phase_count <= phase_count + 1;
    end
  end

  // write in the high half so it lands before the next falling edge
  task automatic put(input logic [11:0] word, input logic [1:0] sel);
    @(posedge conversion_clock);
    @(posedge clock);
    {chip_select_low_active, chip_select_high_active} <= sel;
    data_in <= word;
    write_strobe_b <= 1'b0;
    repeat (8) @(posedge clock);
    write_strobe_b <= 1'b1;
    repeat (6) @(posedge clock);
    data_in <= ~word; // a released bus must not keep showing the last word
  endtask : put

  // one read per conversion period, after setup past the falling edge
  task automatic get(input logic [1:0] sel, output logic [11:0] word, output logic mark,
    output logic oe);
    @(negedge conversion_clock);
    repeat (8) @(posedge clock);
    {chip_select_low_active, chip_select_high_active} <= sel;
    read_strobe_b <= 1'b0;
    repeat (8) @(posedge clock);
    word = data_out;
    mark = channel_one_marker_b;
    oe = data_oe;
    read_strobe_b <= 1'b1;
  endtask : get
endmodule : host_bus_model

//--- tb_adc_channel_sync_host_port.sv
`timescale 1ns/1ps
`include "adc_sync_port_map.svh"
`define check(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end

module tb_adc_channel_sync_host_port;
  localparam bit ten_bit = 1'b0;
  typedef struct {logic [9:0] cwa; int nch;} row_type;
  row_type rows [5] = '{'{10'h000, 1}, '{10'h008, 2}, '{10'h010, 3}, '{10'h018, 4},
    '{10'h028, 2}};
  logic [1:0] bad_sel [3] = '{2'b11, 2'b00, 2'b10};
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [`BUS_WIDTH-1:0] smp [4] = '{default: 12'h000};
  logic conv, rd_b, wr_b, csl, csh, oe, mark, m, o;
  logic [`BUS_WIDTH-1:0] din, dout, w;
  logic [`REG_WIDTH-1:0] cwa, cwb;
  logic [`BUS_WIDTH-1:0] dout2;
  logic mark2;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  initial forever #50 clock = ~clock;

  adc_channel_sync_host_port #(.ten_bit_variant(ten_bit), .two_input_variant(1'b0)) DUT (
    .clock(clock), .rst_b(rst_b), .conversion_clock(conv), .read_strobe_b(rd_b),
    .write_strobe_b(wr_b), .chip_select_low_active(csl), .chip_select_high_active(csh),
    .data_in(din), .sample_ch1(smp[0]), .sample_ch2(smp[1]), .sample_ch3(smp[2]),
    .sample_ch4(smp[3]), .data_out(dout), .data_oe(oe), .channel_one_marker_b(mark),
    .control_word_a(cwa), .control_word_b(cwb));

  // narrow readback and two-input channel mapping, fed by the same host
  adc_channel_sync_host_port #(.ten_bit_variant(1'b1), .two_input_variant(1'b1)) DUT2 (
    .clock(clock), .rst_b(rst_b), .conversion_clock(conv), .read_strobe_b(rd_b),
    .write_strobe_b(wr_b), .chip_select_low_active(csl), .chip_select_high_active(csh),
    .data_in(din), .sample_ch1(smp[0]), .sample_ch2(smp[1]), .sample_ch3(smp[2]),
    .sample_ch4(smp[3]), .data_out(dout2), .data_oe(), .channel_one_marker_b(mark2),
    .control_word_a(), .control_word_b());

  host_bus_model #(.half_period(20)) host (.clock(clock), .data_out(dout), .data_oe(oe),
    .channel_one_marker_b(mark), .conversion_clock(conv), .read_strobe_b(rd_b),
    .write_strobe_b(wr_b), .chip_select_low_active(csl), .chip_select_high_active(csh),
    .data_in(din));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [11:0] readback(input logic [9:0] v, input bit narrow);
    logic [11:0] word;
    word = {2'h0, v};
    if (narrow) word = word >> 2;
    return word | 12'h010;
  endfunction : readback

  task automatic complete_run;
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task automatic do_reset;
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    `check(cwa, 10'h020)
    `check(cwb, 10'h030)
    `check(mark, 1'b1)
    `check(oe, 1'b0)
    `check(mark2, 1'b1)
  endtask : do_reset

  // configure, realign with bit 1 left set, then read two whole scans
  task automatic run_row(input logic [9:0] cfg, input int nch);
    int ch;
    host.put({2'h0, cfg}, 2'b01);
    host.put(12'h402, 2'b01);
    `check(cwa, cfg)
    for (int k = 0; k < 2 * nch; k++) begin
      host.get(2'b01, w, m, o);
      ch = k % nch;
      `check(w, smp[ch])
      `check(m, (nch > 1 && ch == 0) ? 1'b0 : 1'b1)
      `check(o, 1'b1)
    end
  endtask : run_row

  // hang guard, about five times the expected run
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      num_errors++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    do_reset();
    host.put(12'h018, 2'b01);
    host.put(12'h401, 2'b01);
    `check(cwa, 10'h020)
    `check(cwb, 10'h030)
    host.put(12'h400, 2'b01);
    `check(cwb, 10'h000)
    foreach (rows[i]) begin
      for (int k = 0; k < 4; k++) smp[k] <= {4'h1, i[3:0], 2'h0, k[1:0]};
      run_row(rows[i].cwa, rows[i].nch);
    end
    // strobes without a full select are ignored, which also skips reads
    foreach (bad_sel[j]) begin
      host.get(bad_sel[j], w, m, o);
      `check(o, 1'b0)
      host.put(12'h3FF, bad_sel[j]);
      `check(cwa, 10'h028)
    end
    host.put(12'h602, 2'b01);
    host.get(2'b01, w, m, o);
    `check(w, readback(10'h028, ten_bit))
    `check(dout2, readback(10'h028, 1'b1))
    `check(m, 1'b0)
    `check(mark2, 1'b0)
    host.get(2'b01, w, m, o);
    `check(w, readback(10'h202, ten_bit))
    `check(dout2, readback(10'h202, 1'b1))
    // skipped reads and readback left the marker stale; realign recovers it
    run_row(10'h010, 3);
    // two inputs cannot carry three channels, so that part stays single
    `check(mark2, 1'b1)
    do_reset();
    complete_run();
  end
endmodule : tb_adc_channel_sync_host_port
